// ==== verilog/hscr_consts.svh ====
// address map, field positions, reset values and codes of the shared control register bank
`ifndef HSCR_CONSTS_SVH
`define HSCR_CONSTS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define HSCR_ADDR_IND_CTL     8'hb0
`define HSCR_ADDR_IND_OFFSET  8'hb1
`define HSCR_ADDR_IND_DATA    8'hb2
`define HSCR_ADDR_ST_CTL      8'hb3
`define HSCR_ADDR_RSVD_B4     8'hb4
`define HSCR_ADDR_RSVD_B5     8'hb5
`define HSCR_ADDR_RSVD_B6     8'hb6
`define HSCR_ADDR_RSVD_B7     8'hb7
`define HSCR_ADDR_STRAP_STS   8'hb8
`define HSCR_ADDR_LEM_CTL     8'hb9

// ****************************************************************
// reset values
// ****************************************************************
`define HSCR_RST_IND_CTL      8'h1c
`define HSCR_RST_IND_OFFSET   8'h00
`define HSCR_RST_IND_DATA     8'h14
`define HSCR_RST_ST_CTL       8'h08
`define HSCR_RST_RSVD_B4      8'h25
`define HSCR_RST_RSVD_B5      8'h00
`define HSCR_RST_RSVD_B6      8'h18
`define HSCR_RST_RSVD_B7      8'h00
`define HSCR_RST_LEM_CTL      8'h33
`define HSCR_RDATA_IDLE       8'h00

// ****************************************************************
// field positions
// ****************************************************************
`define HSCR_CTL_SEL_HI       5
`define HSCR_CTL_SEL_LO       2
`define HSCR_CTL_STEP_BIT     1
`define HSCR_CTL_PREFETCH_BIT 0
`define HSCR_ST_MODE_HI       7
`define HSCR_ST_MODE_LO       6
`define HSCR_ST_CFG_BIT       3
`define HSCR_ST_SRC_HI        2
`define HSCR_ST_SRC_LO        1
`define HSCR_ST_EN_BIT        0
`define HSCR_LEM_IGNORE_BIT   5
`define HSCR_LEM_COUNT_BIT    4
`define HSCR_LEM_LIMIT_HI     3
`define HSCR_LEM_LIMIT_LO     0

// ****************************************************************
// codes and counts
// ****************************************************************
`define HSCR_SEL_ALL_RX       4'h6
`define HSCR_SER_CLK_SRC_OFF  8'h14
`define HSCR_ST_RSVD_CLK_SRC  2'h0
`define HSCR_OFFSET_STEP      8'h01
`define HSCR_ERR_STEP         4'h1
`define HSCR_ERR_MAX          4'hf
`define HSCR_ERR_ZERO         4'h0

`endif

// ==== verilog/hscr_pkg.sv ====
// types shared by the shared control register bank
package hscr_pkg;

	// request toward the internal register blocks
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic       all_rx;
		logic [3:0] sel;
		logic [7:0] offset;
		logic [7:0] wdata;
	} hscr_ind_req_type;

	// self-test setup toward the test data path
	typedef struct packed {
		logic       enable;
		logic [1:0] out_mode;
		logic       cfg_from_reg;
		logic [1:0] clock_source;
	} hscr_st_type;

	// register write request toward the remote serializer
	typedef struct packed {
		logic       wr;
		logic [7:0] offset;
		logic [1:0] clk_src;
	} hscr_rem_req_type;

	// strap capture sequence
	typedef enum logic [1:0] {
		HSCR_STRAP_FILL  = 2'b00,
		HSCR_STRAP_SETTLE = 2'b01,
		HSCR_STRAP_DONE  = 2'b10,
		HSCR_STRAP_SYNC  = 2'b11
	} hscr_strap_state_type;

endpackage

// ==== verilog/hscr_regs.sv ====
// shared control and status register bank of the deserializer hub
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "hscr_consts.svh"

module hscr_regs (
	input  wire logic                       core_clk,
	input  wire logic                       rst_n,
	input  wire logic                       clk_en,
	input  wire logic [7:0]                 reg_addr,
	input  wire logic [7:0]                 reg_wdata,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	output logic [7:0]                      reg_rdata,
	output hscr_pkg::hscr_ind_req_type      ind_req,
	input  wire logic [7:0]                 ind_rdata,
	output hscr_pkg::hscr_st_type           st_ctl,
	output hscr_pkg::hscr_rem_req_type      rem_req,
	input  wire logic [2:0]                 index_strap_pin,
	input  wire logic [2:0]                 mode_strap_pin,
	input  wire logic                       link_err,
	input  wire logic                       filter_settle,
	input  wire logic                       relock,
	output logic                            lock_lost
);

	// ****************************************************************
	// storage
	// ****************************************************************
	logic [7:0]                     ind_ctl_r;
	logic [7:0]                     ind_offset_r;
	logic [7:0]                     ind_data_r;
	logic [7:0]                     st_ctl_r;
	logic [7:0]                     lem_ctl_r;
	logic [7:0]                     reg_rdata_r;
	logic [7:0]                     rdata_nxt;
	logic                           ind_wr_r;
	logic                           ind_rd_r;
	logic [7:0]                     ind_req_off_r;
	logic                           rem_wr_r;
	logic [1:0]                     rem_src_r;
	logic [2:0]                     index_sync1_r;
	logic [2:0]                     index_sync2_r;
	logic [2:0]                     mode_sync1_r;
	logic [2:0]                     mode_sync2_r;
	logic [2:0]                     index_strap_value_r;
	logic [2:0]                     mode_strap_value_r;
	logic                           index_decode_complete_r;
	logic                           mode_decode_complete_r;
	hscr_pkg::hscr_strap_state_type strap_state_r;
	logic [3:0]                     err_cnt_r;
	logic                           lock_lost_r;

	// ****************************************************************
	// decode
	// ****************************************************************
	logic       wr_ctl;
	logic       wr_off;
	logic       wr_data;
	logic       rd_data;
	logic       wr_st;
	logic       wr_lem;
	logic       indirect_offset_step_enable;
	logic       prefetch_enable;
	logic [3:0] indirect_target_select;
	logic [1:0] st_src_eff;
	logic       err_valid;
	logic [3:0] link_error_limit;
	logic [3:0] err_cnt_nxt;

	assign wr_ctl  = clk_en && reg_wr && (reg_addr == `HSCR_ADDR_IND_CTL);
	assign wr_off  = clk_en && reg_wr && (reg_addr == `HSCR_ADDR_IND_OFFSET);
	assign wr_data = clk_en && reg_wr && (reg_addr == `HSCR_ADDR_IND_DATA);
	assign rd_data = clk_en && reg_rd && (reg_addr == `HSCR_ADDR_IND_DATA);
	assign wr_st   = clk_en && reg_wr && (reg_addr == `HSCR_ADDR_ST_CTL);
	assign wr_lem  = clk_en && reg_wr && (reg_addr == `HSCR_ADDR_LEM_CTL);

	// control fields
	assign indirect_offset_step_enable = ind_ctl_r[`HSCR_CTL_STEP_BIT];
	assign prefetch_enable             = ind_ctl_r[`HSCR_CTL_PREFETCH_BIT];
	assign indirect_target_select      = ind_ctl_r[`HSCR_CTL_SEL_HI:`HSCR_CTL_SEL_LO];
	assign link_error_limit            = lem_ctl_r[`HSCR_LEM_LIMIT_HI:`HSCR_LEM_LIMIT_LO];

	// ****************************************************************
	// indirect access window
	// ****************************************************************

	// control register: target select, step and prefetch bits
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ind_ctl_r <= `HSCR_RST_IND_CTL;
		end else if (wr_ctl) begin
			ind_ctl_r <= reg_wdata;
		end
	end

	// offset register; a host write beats an increment in the same cycle
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ind_offset_r <= `HSCR_RST_IND_OFFSET;
		end else if (wr_off) begin
			ind_offset_r <= reg_wdata;
		end else if ((wr_data || rd_data) && indirect_offset_step_enable) begin
			ind_offset_r <= ind_offset_r + `HSCR_OFFSET_STEP;
		end
	end

	// last value written to the window, carried with the write strobe
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ind_data_r <= `HSCR_RST_IND_DATA;
		end else if (wr_data) begin
			ind_data_r <= reg_wdata;
		end
	end

	// strobes toward the target, one cycle after the host access; the
	// offset beside them is a flop: the old offset under a write strobe,
	// the stepped one under a read prefetch, else the offset register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ind_wr_r      <= 1'b0;
			ind_rd_r      <= 1'b0;
			ind_req_off_r <= `HSCR_RST_IND_OFFSET;
		end else if (clk_en) begin
			ind_wr_r <= wr_data;
			// prefetch on new offset, or on a window read when stepping
			ind_rd_r <= prefetch_enable && (wr_off || (rd_data && indirect_offset_step_enable));
			if (wr_off) begin
				ind_req_off_r <= reg_wdata;
			end else if (rd_data && indirect_offset_step_enable) begin
				ind_req_off_r <= ind_offset_r + `HSCR_OFFSET_STEP;
			end else begin
				ind_req_off_r <= ind_offset_r;
			end
		end
	end

	// broadcast flag registered from the select field
	logic ind_all_rx_r;

	assign ind_req = '{wr: ind_wr_r, rd: ind_rd_r, all_rx: ind_all_rx_r,
	                   sel: ind_ctl_r[`HSCR_CTL_SEL_HI:`HSCR_CTL_SEL_LO],
	                   offset: ind_req_off_r, wdata: ind_data_r};

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ind_all_rx_r <= 1'b0;
		end else if (clk_en) begin
			ind_all_rx_r <= wr_ctl ? (reg_wdata[`HSCR_CTL_SEL_HI:`HSCR_CTL_SEL_LO] == `HSCR_SEL_ALL_RX)
			                       : (indirect_target_select == `HSCR_SEL_ALL_RX);
		end
	end

	// ****************************************************************
	// self-test control
	// ****************************************************************

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ctl_r <= `HSCR_RST_ST_CTL;
		end else if (wr_st) begin
			st_ctl_r <= reg_wdata;
		end
	end

	assign st_src_eff = reg_wdata[`HSCR_ST_CFG_BIT] ? `HSCR_ST_RSVD_CLK_SRC
	                                                : reg_wdata[`HSCR_ST_SRC_HI:`HSCR_ST_SRC_LO];

	// serializer copy fires once on the off-to-on write only; rewriting an
	// already enabled test still changes rem_req.clk_src and st_ctl.clock_source, with no new strobe
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rem_wr_r  <= 1'b0;
			rem_src_r <= `HSCR_ST_RSVD_CLK_SRC;
		end else if (clk_en) begin
			rem_wr_r <= wr_st && reg_wdata[`HSCR_ST_EN_BIT] && !st_ctl_r[`HSCR_ST_EN_BIT];
			if (wr_st) begin
				rem_src_r <= st_src_eff;
			end
		end
	end

	// self-test setup passed to test path, clock source copy to serializer request
	assign st_ctl.enable       = st_ctl_r[`HSCR_ST_EN_BIT];
	assign st_ctl.out_mode     = st_ctl_r[`HSCR_ST_MODE_HI:`HSCR_ST_MODE_LO];
	assign st_ctl.cfg_from_reg = !st_ctl_r[`HSCR_ST_CFG_BIT];
	assign st_ctl.clock_source = rem_src_r;
	assign rem_req.wr          = rem_wr_r;
	assign rem_req.offset      = `HSCR_SER_CLK_SRC_OFF;
	assign rem_req.clk_src     = rem_src_r;

	// ****************************************************************
	// strap capture
	// ****************************************************************

	// two-stage synchronisers; only stage two feeds the latch
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			index_sync1_r <= 3'h0;
			index_sync2_r <= 3'h0;
			mode_sync1_r  <= 3'h0;
			mode_sync2_r  <= 3'h0;
		end else if (clk_en) begin
			index_sync1_r <= index_strap_pin;
			index_sync2_r <= index_sync1_r;
			mode_sync1_r  <= mode_strap_pin;
			mode_sync2_r  <= mode_sync1_r;
		end
	end

	// wait two edges for stage two to hold the pins, then latch once and hold;
	// latching earlier would capture the synchroniser's reset zeros
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			strap_state_r           <= hscr_pkg::HSCR_STRAP_FILL;
			index_strap_value_r     <= 3'h0;
			mode_strap_value_r      <= 3'h0;
			index_decode_complete_r <= 1'b0;
			mode_decode_complete_r  <= 1'b0;
		end else if (clk_en) begin
			unique case (strap_state_r)
				hscr_pkg::HSCR_STRAP_FILL: begin
					strap_state_r <= hscr_pkg::HSCR_STRAP_SYNC;
				end
				hscr_pkg::HSCR_STRAP_SYNC: begin
					strap_state_r <= hscr_pkg::HSCR_STRAP_SETTLE;
				end
				hscr_pkg::HSCR_STRAP_SETTLE: begin
					strap_state_r <= hscr_pkg::HSCR_STRAP_DONE;
					index_strap_value_r <= index_sync2_r;
					mode_strap_value_r <= mode_sync2_r;
					index_decode_complete_r <= 1'b1;
					mode_decode_complete_r <= 1'b1;
				end
				hscr_pkg::HSCR_STRAP_DONE: begin
					strap_state_r <= hscr_pkg::HSCR_STRAP_DONE;
				end
			endcase
		end
	end

	// ****************************************************************
	// link error monitor
	// ****************************************************************

	assign err_valid   = link_err && !(lem_ctl_r[`HSCR_LEM_IGNORE_BIT] && filter_settle);
	assign err_cnt_nxt = (err_cnt_r == `HSCR_ERR_MAX) ? err_cnt_r : err_cnt_r + `HSCR_ERR_STEP;

	// monitor control: ignore and count enables, limit
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			lem_ctl_r <= `HSCR_RST_LEM_CTL;
		end else if (wr_lem) begin
			lem_ctl_r <= reg_wdata;
		end
	end

	// lock stays lost until the receiver relocks; relock wins over an error
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			err_cnt_r   <= `HSCR_ERR_ZERO;
			lock_lost_r <= 1'b0;
		end else if (clk_en) begin
			if (relock) begin
				err_cnt_r   <= `HSCR_ERR_ZERO;
				lock_lost_r <= 1'b0;
			end else if (err_valid && !lock_lost_r) begin
				if (lem_ctl_r[`HSCR_LEM_COUNT_BIT]) begin
					err_cnt_r <= err_cnt_nxt;
					lock_lost_r <= (err_cnt_nxt >= link_error_limit);
				end else begin
					lock_lost_r <= 1'b1;
				end
			end
		end
	end

	assign lock_lost = lock_lost_r;

	// ****************************************************************
	// register read port
	// ****************************************************************

	// read mux; unmapped offsets answer zero
	always_comb begin
		rdata_nxt = `HSCR_RDATA_IDLE;
		unique case (reg_addr)
			`HSCR_ADDR_IND_CTL:    rdata_nxt = ind_ctl_r;
			`HSCR_ADDR_IND_OFFSET: rdata_nxt = ind_offset_r;
			`HSCR_ADDR_IND_DATA:   rdata_nxt = ind_rdata;
			`HSCR_ADDR_ST_CTL:     rdata_nxt = st_ctl_r;
			`HSCR_ADDR_RSVD_B4:    rdata_nxt = `HSCR_RST_RSVD_B4;
			`HSCR_ADDR_RSVD_B5:    rdata_nxt = `HSCR_RST_RSVD_B5;
			`HSCR_ADDR_RSVD_B6:    rdata_nxt = `HSCR_RST_RSVD_B6;
			`HSCR_ADDR_RSVD_B7:    rdata_nxt = `HSCR_RST_RSVD_B7;
			`HSCR_ADDR_STRAP_STS:  rdata_nxt = {index_decode_complete_r, index_strap_value_r,
			                                    mode_decode_complete_r, mode_strap_value_r};
			`HSCR_ADDR_LEM_CTL:    rdata_nxt = lem_ctl_r;
			default:               rdata_nxt = `HSCR_RDATA_IDLE;
		endcase
	end

	// read data stand for one cycle only, zero otherwise
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_r <= `HSCR_RDATA_IDLE;
		end else if (clk_en) begin
			reg_rdata_r <= reg_rd ? rdata_nxt : `HSCR_RDATA_IDLE;
		end
	end

	assign reg_rdata = reg_rdata_r;

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence s_enable_write;
		wr_st && reg_wdata[`HSCR_ST_EN_BIT] && !st_ctl_r[`HSCR_ST_EN_BIT];
	endsequence
	sequence s_remote_copy;
		rem_req.wr && (rem_req.offset == `HSCR_SER_CLK_SRC_OFF) ##1 !rem_req.wr;
	endsequence

	property p_offset_write;
		wr_off |=> (ind_offset_r == $past(reg_wdata));
	endproperty
	a_offset_write: assert property (p_offset_write) else $error("offset not stored");

	property p_ind_write;
		wr_data |=> ind_req.wr && (ind_req.wdata == $past(reg_wdata)) && (ind_req.offset == $past(ind_offset_r));
	endproperty
	a_ind_write: assert property (p_ind_write) else $error("indirect write not issued");

	property p_ind_read;
		rd_data |=> (reg_rdata == $past(ind_rdata));
	endproperty
	a_ind_read: assert property (p_ind_read) else $error("window read wrong");

	property p_step;
		(wr_data || rd_data) && indirect_offset_step_enable |=> (ind_offset_r == $past(ind_offset_r) + `HSCR_OFFSET_STEP);
	endproperty
	a_step: assert property (p_step) else $error("offset did not step");

	property p_remote_copy;
		s_enable_write |=> s_remote_copy;
	endproperty
	a_remote_copy: assert property (p_remote_copy) else $error("clock source not copied");

	property p_strap_latch;
		$rose(index_decode_complete_r) |-> (index_strap_value_r == $past(index_sync2_r))
			&& mode_decode_complete_r ##1 index_decode_complete_r [*3];
	endproperty
	a_strap_latch: assert property (p_strap_latch) else $error("strap latch wrong");

	property p_first_error;
		clk_en && !relock && err_valid && !lem_ctl_r[`HSCR_LEM_COUNT_BIT] |=> lock_lost;
	endproperty
	a_first_error: assert property (p_first_error) else $error("lock kept after error");

	property p_settle_ignore;
		clk_en && !relock && link_err && filter_settle && lem_ctl_r[`HSCR_LEM_IGNORE_BIT] && !lock_lost_r
			|=> !lock_lost && $stable(err_cnt_r);
	endproperty
	a_settle_ignore: assert property (p_settle_ignore) else $error("settle error counted");

	property p_reserved_read;
		clk_en && reg_rd && (reg_addr == `HSCR_ADDR_RSVD_B4) |=> (reg_rdata == `HSCR_RST_RSVD_B4);
	endproperty
	a_reserved_read: assert property (p_reserved_read) else $error("reserved read wrong");

endmodule
`default_nettype wire

// ==== testbench/hscr_regs_test.sv ====
// self-checking testbench of the shared control register bank
`timescale 1ns/1ps
`default_nettype none
`include "hscr_consts.svh"

module hscr_regs_test;
	logic                             core_clk = 1'b0;
	logic                             rst_n = 1'b0;
	logic                             clk_en = 1'b1;
	logic [7:0]                       reg_addr = 8'h00;
	logic [7:0]                       reg_wdata = 8'h00;
	logic                             reg_wr = 1'b0;
	logic                             reg_rd = 1'b0;
	logic [7:0]                       reg_rdata;
	logic [7:0]                       ind_rdata;
	logic [2:0]                       idx_pin;
	logic [2:0]                       mode_pin;
	logic                             link_err = 1'b0;
	logic                             filter_settle = 1'b0;
	logic                             relock = 1'b0;
	logic                             lock_lost;
	hscr_pkg::hscr_ind_req_type       ind_req;
	hscr_pkg::hscr_st_type            st_ctl;
	hscr_pkg::hscr_rem_req_type       rem_req;
	integer                           seed = 24;
	int                               err_count = 0;
	int                               checked = 0;
	logic [7:0]                       v, off, d, ctl;
	logic [3:0]                       sel;
	logic                             step;

	hscr_regs dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ind_req(ind_req),
		.ind_rdata(ind_rdata), .st_ctl(st_ctl), .rem_req(rem_req), .index_strap_pin(idx_pin),
		.mode_strap_pin(mode_pin), .link_err(link_err), .filter_settle(filter_settle), .relock(relock),
		.lock_lost(lock_lost));

	// 100 ns period
	always #50 core_clk = ~core_clk;

	// target blocks answer with a pattern tied to selection and offset
	assign ind_rdata = ind_req.offset ^ {ind_req.sel, 4'h5};

	// ****************************************************************
	// helpers
	// ****************************************************************
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test;
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// one-cycle write; returns just after the taking edge
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] wd);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= wd;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	// one-cycle read; data sampled inside the answer cycle only
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] rd);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 rd = reg_rdata;
	endtask

	task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
		rd_reg(a, v);
		check(v, exp);
	endtask

	// pulses of link_err, then lock state after it settles
	task automatic errs(input int n, input logic exp);
		repeat (n) begin
			@(posedge core_clk);
			link_err <= 1'b1;
			@(posedge core_clk);
			link_err <= 1'b0;
		end
		repeat (2) @(posedge core_clk);
		#1 check(8'(lock_lost), 8'(exp));
	endtask

	task automatic do_relock;
		@(posedge core_clk);
		relock <= 1'b1;
		@(posedge core_clk);
		relock <= 1'b0;
	endtask

	// effective clock source: reserved setup forces the fixed value
	function automatic logic [1:0] exp_src(input logic [7:0] r);
		return r[3] ? `HSCR_ST_RSVD_CLK_SRC : r[2:1];
	endfunction

	// a hang costs a mismatch and ends the run
	initial begin
		repeat (20000) @(posedge core_clk);
		err_count++;
		stop_test();
	end

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		idx_pin <= 3'($random(seed));
		mode_pin <= 3'($random(seed));
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		// reset contents, reserved places and unmapped space
		rd_check(`HSCR_ADDR_IND_CTL, 8'h1c);
		rd_check(`HSCR_ADDR_IND_OFFSET, 8'h00);
		rd_check(`HSCR_ADDR_ST_CTL, 8'h08);
		rd_check(`HSCR_ADDR_LEM_CTL, 8'h33);
		rd_check(`HSCR_ADDR_STRAP_STS, {1'b1, idx_pin, 1'b1, mode_pin});
		check(v[6:4], 8'(idx_pin));
		check(v[3], 1'b1);
		check(v[2:0], 8'(mode_pin));
		for (int i = 0; i < 4; i++) begin
			wr_reg(8'hb4 + 8'(i), 8'hff);
			rd_check(8'hb4 + 8'(i), (i == 0) ? 8'h25 : (i == 2) ? 8'h18 : 8'h00);
		end
		rd_check(8'hc0, 8'h00);
		// indirect window, stepping on and off, broadcast selection then random selections 0 to 7
		for (int i = 0; i < 8; i++) begin
			sel = (i == 0) ? 4'h6 : 4'($random(seed)) & 4'h7;
			step = i[0];
			ctl = {2'b00, sel, step, step};
			wr_reg(`HSCR_ADDR_IND_CTL, ctl);
			off = 8'($random(seed));
			d = 8'($random(seed));
			wr_reg(`HSCR_ADDR_IND_OFFSET, off);
			#1 check(8'(ind_req.rd), 8'(step));
			wr_reg(`HSCR_ADDR_IND_DATA, d);
			#1 check(8'(ind_req.wr), 8'h01);
			check(ind_req.wdata, d);
			check(ind_req.offset, off);
			check(8'(ind_req.sel), 8'(sel));
			check(8'(ind_req.all_rx), 8'(sel == `HSCR_SEL_ALL_RX));
			rd_check(`HSCR_ADDR_IND_DATA, (off + 8'(step)) ^ {sel, 4'h5});
			check(8'(ind_req.rd), 8'(step));
			check(ind_req.offset, off + 8'(step) + 8'(step));
			rd_check(`HSCR_ADDR_IND_OFFSET, off + 8'(step) + 8'(step));
		end
		// frozen clock enable loses the write
		@(posedge core_clk);
		clk_en <= 1'b0;
		wr_reg(`HSCR_ADDR_IND_OFFSET, ~v);
		@(posedge core_clk);
		clk_en <= 1'b1;
		rd_check(`HSCR_ADDR_IND_OFFSET, v);
		// self-test: every output mode, random setup source
		for (int m = 0; m < 4; m++) begin
			d = {2'(m), 2'b00, 1'($random(seed)), 2'($random(seed)), 1'b1};
			wr_reg(`HSCR_ADDR_ST_CTL, d);
			#1 check(8'(rem_req.wr), 8'h01);
			check(rem_req.offset, `HSCR_SER_CLK_SRC_OFF);
			check(8'(rem_req.clk_src), 8'(exp_src(d)));
			check(8'(st_ctl.enable), 8'h01);
			check(8'(st_ctl.out_mode), 8'(m));
			check(8'(st_ctl.cfg_from_reg), 8'(!d[3]));
			check(8'(st_ctl.clock_source), 8'(exp_src(d)));
			@(posedge core_clk);
			#1 check(8'(rem_req.wr), 8'h00);
			wr_reg(`HSCR_ADDR_ST_CTL, d & 8'hfe);
			#1 check(8'(st_ctl.enable), 8'h00);
			rd_check(`HSCR_ADDR_ST_CTL, d & 8'hfe);
		end
		// link monitor: default limit, counting off, settle window, top limit
		do_relock();
		errs(2, 1'b0);
		errs(1, 1'b1);
		do_relock();
		wr_reg(`HSCR_ADDR_LEM_CTL, 8'h23);
		errs(1, 1'b1);
		do_relock();
		wr_reg(`HSCR_ADDR_LEM_CTL, 8'h33);
		filter_settle <= 1'b1;
		errs(4, 1'b0);
		wr_reg(`HSCR_ADDR_LEM_CTL, 8'h13);
		errs(3, 1'b1);
		filter_settle <= 1'b0;
		do_relock();
		wr_reg(`HSCR_ADDR_LEM_CTL, 8'h1f);
		errs(14, 1'b0);
		errs(1, 1'b1);
		// reset in mid-run with new straps: flags low until capture ends
		@(posedge core_clk);
		idx_pin <= 3'($random(seed));
		mode_pin <= 3'($random(seed));
		rst_n <= 1'b0;
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		rd_check(`HSCR_ADDR_STRAP_STS, 8'h00);
		rd_check(`HSCR_ADDR_STRAP_STS, {1'b1, idx_pin, 1'b1, mode_pin});
		check(8'(lock_lost), 8'h00);
		stop_test();
	end
endmodule

`default_nettype wire
